// ### src/lms_consts.vh
// Register map, strap fields, mode codes and timing counts of the strap and link-mode block
`ifndef LMS_CONSTS_VH
`define LMS_CONSTS_VH
`define LMS_REG_INPUT_CFG 8'h4f
`define LMS_REG_LINK_CTL 8'h5b
`define LMS_REG_RPT_CFG 8'hc2
`define LMS_REG_STATUS 8'h5c
`define LMS_REG_FREQ 8'h5d
`define LMS_BIT_DUAL_PIX 6
`define LMS_BIT_MAPPING 7
`define LMS_BIT_CABLE 7
`define LMS_BIT_RPT 5
`define LMS_BIT_AUTO_OFF 0
`define LMS_FLD_FORCE_HI 2
`define LMS_FLD_FORCE_LO 1
`define LMS_BIT_PROT 3
`define LMS_RST_INPUT_CFG 8'h00
`define LMS_RST_LINK_CTL 8'h00
`define LMS_RST_RPT_CFG 8'h00
`define LMS_MODE_SINGLE 2'h0
`define LMS_MODE_DUAL 2'h1
`define LMS_MODE_REPL 2'h2
`define LMS_MODE_SEC 2'h3
`define LMS_ADDR_BASE 7'h0c
`define LMS_CLK_MHZ 100
`define LMS_FREQ_WIN_NS 1000
`define LMS_FREQ_WIN_CYC ((`LMS_FREQ_WIN_NS * `LMS_CLK_MHZ) / 1000)
`define LMS_SINGLE_NEW_MAX_MHZ 8'd96
`define LMS_SINGLE_OLD_MAX_MHZ 8'd85
`define LMS_DUAL_MAX_MHZ 8'd170
`define LMS_REPL_MAX_MHZ 8'd85
`endif

// ### src/lms_link_mode_strap_config.v
// Strap decode, control-bus slave and link-mode selection of the serializer configuration block
`timescale 1ns/1ps
`include "lms_consts.vh"

// Notes on behaviour
// - Second strap level 1-2 map0 cable0, 3-4 map0 cable1, 5-6 map1 cable0, 7-8 map1 cable1.
// - Dual-pixel strap stored inverted in input config bit 6.
// - Repeater to 0xC2[5], mapping to 0x4F[7], cable to 0x5B[7], non-inverted.
// - All mode-strap-derived bits remain software readable and writable after latching; the strapped slave address is neither.
// - Single link sends all video on one downlink; up to 96 MHz with newer receiver.
// - Single link with an older receiver is limited below 85 MHz.
// - Forced single mode disables the secondary transmitter and its back channel.
// - Dual link alternates consecutive pixels between the two downlinks.
// - Dual link with protection enabled uses one session covering both links.
// - Dual link supports up to 170 MHz, each port at half pixel rate.
// - Enter dual automatically with dual-capable receiver above minimum frequency, or forced.
// - Replicate mode runs second protection engine, same video to two receivers, 85 MHz max.
// - Detect downstream capabilities; two independent receivers select replicate mode.
// - Receiver only on secondary link routes video to the secondary link alone.
// - Measure pixel-clock frequency and use it with capabilities to pick the mode.
// - Link control register can disable automatic detection so forced modes apply.
// - Address strap level picks slave address 0x0C to 0x1A in steps of two.
// - Transactions start with START or repeated START and end with STOP.
// - Acknowledge a matching address by pulling data low; leave released otherwise.
// - Acknowledge each byte the host writes.
// - Straps sampled once at power-up and held until software changes them.
// - First strap level 1 gives 0/0, 2 gives 0/1, 5 gives 1/0, 6 gives 1/1.
module lms_link_mode_strap_config #(
	parameter [7:0] DUAL_MIN_MHZ = 8'd25
) (
	input wire core_clk,
	input wire rst,
	input wire [2:0] firstModeStrapLevel,
	input wire [2:0] secondModeStrapLevel,
	input wire [2:0] addressStrapLevel,
	input wire scl,
	input wire sdaIn,
	output wire sdaOut,
	output wire sdaOe,
	input wire pixClk,
	input wire primaryRxPresent,
	input wire primaryRxDualCapable,
	input wire primaryRxLegacy,
	input wire secondaryRxPresent,
	output wire [1:0] linkMode,
	output wire primaryTxEnable,
	output wire secondaryTxEnable,
	output wire secondaryBackChannelEnable,
	output wire pixelLinkSelect,
	output wire txHalfClk,
	output wire singleProtectionSession,
	output wire secondProtectionEngine,
	output wire overRate,
	output wire dualPixelInput,
	output wire repeaterEnable,
	output wire bitMappingSelect,
	output wire cableModeBit,
	output wire [6:0] slaveAddress
);
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_ADDR = 4'h1;
	localparam [3:0] S_AACK = 4'h2;
	localparam [3:0] S_REG = 4'h3;
	localparam [3:0] S_RACK = 4'h4;
	localparam [3:0] S_WDATA = 4'h5;
	localparam [3:0] S_WACK = 4'h6;
	localparam [3:0] S_RDATA = 4'h7;
	localparam [3:0] S_MACK = 4'h8;
	localparam [31:0] WIN_CYC = `LMS_FREQ_WIN_CYC;
	localparam [7:0] WIN_LAST = WIN_CYC[7:0] - 8'd1;

	reg [2:0] sclSync_q, sdaSync_q, pixSync_q;
	reg sclF_q, sdaF_q, pixF_q;
	reg [7:0] inputCfg_q, linkCtl_q, rptCfg_q;
	reg [6:0] slaveAddr_q;
	reg strapDone_q;
	reg [3:0] state_q;
	reg [3:0] bitCnt_q;
	reg [7:0] rxShift_q, txShift_q, ptr_q;
	reg rw_q, hostAck_q, sdaDrive_q;
	reg [7:0] winCnt_q, edgeCnt_q, freqMhz_q;
	reg [1:0] mode_q;
	reg pixSel_q, halfClk_q, overRate_q;
	reg [1:0] autoMode, nextMode;
	reg [7:0] rdData;
	reg strapMap, strapCable, strapDual, strapRpt;
	wire sclRise, sclFall, startCond, stopCond, pixRise;
	wire sclNew, sdaNew, pixNew;

	// Three-stage samplers; a change counts once stages two and three agree
	always @(posedge core_clk) begin
		if (rst) begin
			sclSync_q <= 3'h7;
			sdaSync_q <= 3'h7;
			pixSync_q <= 3'h0;
			sclF_q <= 1'b1;
			sdaF_q <= 1'b1;
			pixF_q <= 1'b0;
		end else begin
			sclSync_q <= {sclSync_q[1:0], scl};
			sdaSync_q <= {sdaSync_q[1:0], sdaIn};
			pixSync_q <= {pixSync_q[1:0], pixClk};
			if (sclSync_q[1] == sclSync_q[2]) sclF_q <= sclSync_q[2];
			if (sdaSync_q[1] == sdaSync_q[2]) sdaF_q <= sdaSync_q[2];
			if (pixSync_q[1] == pixSync_q[2]) pixF_q <= pixSync_q[2];
		end
	end

	assign sclNew = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclF_q;
	assign sdaNew = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaF_q;
	assign pixNew = (pixSync_q[1] == pixSync_q[2]) ? pixSync_q[2] : pixF_q;
	assign sclRise = sclNew & ~sclF_q;
	assign sclFall = ~sclNew & sclF_q;
	assign pixRise = pixNew & ~pixF_q;
	// Bus framing seen while the clock line stays high
	assign startCond = sclF_q & sclNew & sdaF_q & ~sdaNew;
	assign stopCond = sclF_q & sclNew & ~sdaF_q & sdaNew;

	// Strap level decode
	always @* begin
		strapMap = secondModeStrapLevel[2];
		strapCable = secondModeStrapLevel[1];
		strapDual = firstModeStrapLevel[2];
		strapRpt = firstModeStrapLevel[0];
	end

	// Register read mux; unmapped offsets read zero
	always @* begin
		case (ptr_q)
			`LMS_REG_INPUT_CFG: rdData = inputCfg_q;
			`LMS_REG_LINK_CTL: rdData = linkCtl_q;
			`LMS_REG_RPT_CFG: rdData = rptCfg_q;
			`LMS_REG_STATUS: rdData = {5'h00, overRate_q, mode_q};
			`LMS_REG_FREQ: rdData = freqMhz_q;
			default: rdData = 8'h00;
		endcase
	end

	// Control-bus slave with strap latch and register writes
	always @(posedge core_clk) begin
		if (rst) begin
			inputCfg_q <= `LMS_RST_INPUT_CFG;
			linkCtl_q <= `LMS_RST_LINK_CTL;
			rptCfg_q <= `LMS_RST_RPT_CFG;
			slaveAddr_q <= `LMS_ADDR_BASE;
			strapDone_q <= 1'b0;
			state_q <= S_IDLE;
			bitCnt_q <= 4'h0;
			rxShift_q <= 8'h00;
			txShift_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			hostAck_q <= 1'b0;
			sdaDrive_q <= 1'b0;
		end else if (!strapDone_q) begin
			// One-time capture after reset release
			strapDone_q <= 1'b1;
			inputCfg_q[`LMS_BIT_DUAL_PIX] <= ~strapDual;
			inputCfg_q[`LMS_BIT_MAPPING] <= strapMap;
			linkCtl_q[`LMS_BIT_CABLE] <= strapCable;
			rptCfg_q[`LMS_BIT_RPT] <= strapRpt;
			slaveAddr_q <= `LMS_ADDR_BASE + {3'h0, addressStrapLevel, 1'b0};
		end else if (startCond) begin
			state_q <= S_ADDR;
			bitCnt_q <= 4'h0;
			sdaDrive_q <= 1'b0;
		end else if (stopCond) begin
			state_q <= S_IDLE;
			sdaDrive_q <= 1'b0;
		end else if (sclRise) begin
			// Sample on the rising clock edge
			case (state_q)
				S_ADDR, S_REG, S_WDATA: begin
					rxShift_q <= {rxShift_q[6:0], sdaF_q};
					bitCnt_q <= bitCnt_q + 4'h1;
				end
				S_RDATA: begin
					txShift_q <= {txShift_q[6:0], 1'b0};
					bitCnt_q <= bitCnt_q + 4'h1;
				end
				S_MACK: hostAck_q <= ~sdaF_q;
				default: ;
			endcase
		end else if (sclFall) begin
			// Drive or release the data line on the falling clock edge
			case (state_q)
				S_ADDR: if (bitCnt_q == 4'h8) begin
					bitCnt_q <= 4'h0;
					if (rxShift_q[7:1] == slaveAddr_q) begin
						rw_q <= rxShift_q[0];
						sdaDrive_q <= 1'b1;
						state_q <= S_AACK;
					end else begin
						state_q <= S_IDLE;
					end
				end
				S_AACK: if (rw_q) begin
					txShift_q <= rdData;
					sdaDrive_q <= ~rdData[7];
					state_q <= S_RDATA;
				end else begin
					sdaDrive_q <= 1'b0;
					state_q <= S_REG;
				end
				S_REG: if (bitCnt_q == 4'h8) begin
					bitCnt_q <= 4'h0;
					ptr_q <= rxShift_q;
					sdaDrive_q <= 1'b1;
					state_q <= S_RACK;
				end
				S_RACK, S_WACK: begin
					sdaDrive_q <= 1'b0;
					state_q <= S_WDATA;
				end
				S_WDATA: if (bitCnt_q == 4'h8) begin
					bitCnt_q <= 4'h0;
					case (ptr_q)
						`LMS_REG_INPUT_CFG: inputCfg_q <= rxShift_q;
						`LMS_REG_LINK_CTL: linkCtl_q <= rxShift_q;
						`LMS_REG_RPT_CFG: rptCfg_q <= rxShift_q;
						default: ;
					endcase
					ptr_q <= ptr_q + 8'h01;
					sdaDrive_q <= 1'b1;
					state_q <= S_WACK;
				end
				S_RDATA: if (bitCnt_q == 4'h8) begin
					bitCnt_q <= 4'h0;
					ptr_q <= ptr_q + 8'h01;
					sdaDrive_q <= 1'b0;
					state_q <= S_MACK;
				end else begin
					sdaDrive_q <= ~txShift_q[7];
				end
				S_MACK: if (hostAck_q) begin
					txShift_q <= rdData;
					sdaDrive_q <= ~rdData[7];
					state_q <= S_RDATA;
				end else begin
					state_q <= S_IDLE;
				end
				default: sdaDrive_q <= 1'b0;
			endcase
		end
	end

	// Pixel-clock frequency: rising edges per fixed window give MHz
	always @(posedge core_clk) begin
		if (rst) begin
			winCnt_q <= 8'h00;
			edgeCnt_q <= 8'h00;
			freqMhz_q <= 8'h00;
		end else if (winCnt_q == WIN_LAST) begin
			winCnt_q <= 8'h00;
			edgeCnt_q <= {7'h00, pixRise};
			freqMhz_q <= edgeCnt_q;
		end else begin
			winCnt_q <= winCnt_q + 8'h01;
			if (pixRise) edgeCnt_q <= edgeCnt_q + 8'h01;
		end
	end

	// Mode choice from detected receivers and measured frequency
	always @* begin
		if (primaryRxPresent && primaryRxDualCapable && freqMhz_q >= DUAL_MIN_MHZ)
			autoMode = `LMS_MODE_DUAL;
		else if (primaryRxPresent && secondaryRxPresent)
			autoMode = `LMS_MODE_REPL;
		else if (!primaryRxPresent && secondaryRxPresent)
			autoMode = `LMS_MODE_SEC;
		else
			autoMode = `LMS_MODE_SINGLE;
		if (linkCtl_q[`LMS_BIT_AUTO_OFF])
			nextMode = linkCtl_q[`LMS_FLD_FORCE_HI:`LMS_FLD_FORCE_LO];
		else
			nextMode = autoMode;
	end

	// Mode register, pixel steering, half-rate port clock and rate check
	always @(posedge core_clk) begin
		if (rst) begin
			mode_q <= `LMS_MODE_SINGLE;
			pixSel_q <= 1'b0;
			halfClk_q <= 1'b0;
			overRate_q <= 1'b0;
		end else begin
			mode_q <= nextMode;
			if (mode_q == `LMS_MODE_DUAL && pixRise) begin
				pixSel_q <= ~pixSel_q;
				halfClk_q <= ~halfClk_q;
			end else if (mode_q != `LMS_MODE_DUAL) begin
				pixSel_q <= (mode_q == `LMS_MODE_SEC);
				halfClk_q <= 1'b0;
			end
			case (mode_q)
				`LMS_MODE_DUAL: overRate_q <= freqMhz_q > `LMS_DUAL_MAX_MHZ;
				`LMS_MODE_REPL: overRate_q <= freqMhz_q > `LMS_REPL_MAX_MHZ;
				default: overRate_q <= primaryRxLegacy ?
					(freqMhz_q >= `LMS_SINGLE_OLD_MAX_MHZ) :
					(freqMhz_q > `LMS_SINGLE_NEW_MAX_MHZ);
			endcase
		end
	end

	// Output decode
	assign linkMode = mode_q;
	assign primaryTxEnable = (mode_q != `LMS_MODE_SEC);
	assign secondaryTxEnable = (mode_q != `LMS_MODE_SINGLE);
	assign secondaryBackChannelEnable = (mode_q != `LMS_MODE_SINGLE);
	assign pixelLinkSelect = pixSel_q;
	assign txHalfClk = halfClk_q;
	assign singleProtectionSession = (mode_q == `LMS_MODE_DUAL) & linkCtl_q[`LMS_BIT_PROT];
	assign secondProtectionEngine = (mode_q == `LMS_MODE_REPL) & linkCtl_q[`LMS_BIT_PROT];
	assign overRate = overRate_q;
	assign dualPixelInput = ~inputCfg_q[`LMS_BIT_DUAL_PIX];
	assign repeaterEnable = rptCfg_q[`LMS_BIT_RPT];
	assign bitMappingSelect = inputCfg_q[`LMS_BIT_MAPPING];
	assign cableModeBit = linkCtl_q[`LMS_BIT_CABLE];
	assign slaveAddress = slaveAddr_q;
	assign sdaOut = 1'b0;
	assign sdaOe = sdaDrive_q;
endmodule // lms_link_mode_strap_config

// ### tb/lms_checker.sv
// Port checker for the strap and link-mode block
`timescale 1ns/1ps
module lms_checker (
	input wire core_clk,
	input wire rst,
	input wire [2:0] firstModeStrapLevel,
	input wire [2:0] secondModeStrapLevel,
	input wire [2:0] addressStrapLevel,
	input wire scl,
	input wire sdaOe,
	input wire [1:0] linkMode,
	input wire primaryTxEnable,
	input wire secondaryTxEnable,
	input wire secondaryBackChannelEnable,
	input wire pixelLinkSelect,
	input wire txHalfClk,
	input wire singleProtectionSession,
	input wire secondProtectionEngine,
	input wire dualPixelInput,
	input wire repeaterEnable,
	input wire bitMappingSelect,
	input wire cableModeBit,
	input wire [6:0] slaveAddress
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Transmitter enables follow the mode
	property p_prim; primaryTxEnable == (linkMode != 2'h3); endproperty
	a_prim: assert property (p_prim) else $error("primary enable wrong");
	property p_sec;
		secondaryTxEnable == (linkMode != 2'h0) && secondaryBackChannelEnable == secondaryTxEnable;
	endproperty
	a_sec: assert property (p_sec) else $error("secondary enable wrong");
	property p_sess; singleProtectionSession |-> linkMode == 2'h1; endproperty
	a_sess: assert property (p_sess) else $error("session outside dual");
	property p_eng; secondProtectionEngine |-> linkMode == 2'h2; endproperty
	a_eng: assert property (p_eng) else $error("engine outside replicate");
	// Pixel steering and half clock
	property p_half; (linkMode != 2'h1) [*2] |-> !txHalfClk; endproperty
	a_half: assert property (p_half) else $error("half clock outside dual");
	property p_solo; (linkMode == 2'h3) [*2] |-> pixelLinkSelect; endproperty
	a_solo: assert property (p_solo) else $error("secondary-only steering wrong");
	property p_pair;
		(linkMode == 2'h1) [*2] |-> (pixelLinkSelect ^ txHalfClk) == $past(pixelLinkSelect ^ txHalfClk);
	endproperty
	a_pair: assert property (p_pair) else $error("pixel alternation wrong");
	// Straps latched on the first edge after reset
	property p_strap;
		$fell(rst) |=> dualPixelInput == $past(firstModeStrapLevel[2])
			&& repeaterEnable == $past(firstModeStrapLevel[0])
			&& bitMappingSelect == $past(secondModeStrapLevel[2])
			&& cableModeBit == $past(secondModeStrapLevel[1]);
	endproperty
	a_strap: assert property (p_strap) else $error("strap latch wrong");
	property p_addr;
		$fell(rst) |=> slaveAddress == 7'h0c + {3'h0, $past(addressStrapLevel), 1'b0};
	endproperty
	a_addr: assert property (p_addr) else $error("slave address wrong");
	property p_ack; $changed(sdaOe) |-> !scl; endproperty
	a_ack: assert property (p_ack) else $error("data moved while clock high");
	c_dual: cover property (linkMode == 2'h1);
	c_repl: cover property (linkMode == 2'h2);
	c_ack: cover property ($rose(sdaOe));
endmodule // lms_checker

bind lms_link_mode_strap_config lms_checker chk (.core_clk(core_clk), .rst(rst),
	.firstModeStrapLevel(firstModeStrapLevel), .secondModeStrapLevel(secondModeStrapLevel),
	.addressStrapLevel(addressStrapLevel), .scl(scl), .sdaOe(sdaOe), .linkMode(linkMode),
	.primaryTxEnable(primaryTxEnable), .secondaryTxEnable(secondaryTxEnable),
	.secondaryBackChannelEnable(secondaryBackChannelEnable), .pixelLinkSelect(pixelLinkSelect),
	.txHalfClk(txHalfClk), .singleProtectionSession(singleProtectionSession),
	.secondProtectionEngine(secondProtectionEngine), .dualPixelInput(dualPixelInput),
	.repeaterEnable(repeaterEnable), .bitMappingSelect(bitMappingSelect),
	.cableModeBit(cableModeBit), .slaveAddress(slaveAddress));

// ### tb/lms_bus_host.sv
// Control-bus host model driving an open-drain data line
`timescale 1ns/1ps
module lms_bus_host (
	output logic scl,
	output wire sdaLine,
	input wire sdaOe
);
	logic drvLow = 1'b0;
	// Released line floats high through the pull-up
	assign sdaLine = !(drvLow || sdaOe);
	initial scl = 1'b1;
	// Start or repeated start: data falls while clock high
	task automatic start();
		#40 drvLow = 1'b0;
		#60 scl = 1'b1;
		#100 drvLow = 1'b1;
		#100 scl = 1'b0;
	endtask
	// Stop: data rises while clock high
	task automatic stop();
		#40 drvLow = 1'b1;
		#60 scl = 1'b1;
		#100 drvLow = 1'b0;
		#100;
	endtask
	// One bit, data set while clock low
	task automatic bitx(input logic b, output logic r);
		#40 drvLow = !b;
		#60 scl = 1'b1;
		wait (scl);
		#50 r = sdaLine;
		#50 scl = 1'b0;
	endtask
	// Byte MSB first, ninth bit sent as given, acknowledge returned
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(last, r);
		ack = !r;
	endtask
endmodule // lms_bus_host

// ### tb/testbench.sv
// Self-checking testbench of the strap and link-mode block
`timescale 1ns/1ps
`include "lms_consts.vh"
module testbench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic pixClk = 1'b0;
	logic [2:0] firstLvl = 3'h0, secondLvl = 3'h0, addrLvl = 3'h0;
	logic [3:0] rx = 4'h0;
	logic [6:0] dev = 7'h0c;
	logic [5:0] autoTab [4] = '{6'b110001, 6'b100110, 6'b000111, 6'b000000};
	wire [1:0] linkMode;
	wire [6:0] slaveAddress;
	wire scl, sdaIn, sdaOe, secondaryTxEnable, singleProtectionSession, secondProtectionEngine;
	wire dualPixelInput, repeaterEnable, bitMappingSelect, cableModeBit, overRate;
	int error_cnt = 0;
	int total_checks = 0;
	lms_link_mode_strap_config #(.DUAL_MIN_MHZ(8'd5)) uut (.core_clk, .rst,
		.firstModeStrapLevel(firstLvl), .secondModeStrapLevel(secondLvl),
		.addressStrapLevel(addrLvl), .scl, .sdaIn, .sdaOut(), .sdaOe, .pixClk,
		.primaryRxPresent(rx[3]), .primaryRxDualCapable(rx[2]), .primaryRxLegacy(rx[1]),
		.secondaryRxPresent(rx[0]), .linkMode, .primaryTxEnable(), .secondaryTxEnable,
		.secondaryBackChannelEnable(), .pixelLinkSelect(), .txHalfClk(),
		.singleProtectionSession, .secondProtectionEngine, .overRate, .dualPixelInput,
		.repeaterEnable, .bitMappingSelect, .cableModeBit, .slaveAddress);
	lms_bus_host host (.scl(scl), .sdaLine(sdaIn), .sdaOe(sdaOe));
	// Clocks
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		forever #80 pixClk = ~pixClk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic reset_dut();
		@(posedge core_clk) #1 rst = 1'b1;
		repeat (5) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		logic [7:0] q;
		logic [2:0] a;
		host.start();
		host.xfer({dev, 1'b0}, 1'b1, q, a[2]);
		host.xfer(ra, 1'b1, q, a[1]);
		host.xfer(d, 1'b1, q, a[0]);
		host.stop();
		chk({5'h0, a}, 8'h07, "write acks");
	endtask
	task automatic rd(input logic [7:0] ra, input logic [7:0] exp, input string nm);
		logic [7:0] q;
		logic [3:0] a;
		host.start();
		host.xfer({dev, 1'b0}, 1'b1, q, a[3]);
		host.xfer(ra, 1'b1, q, a[2]);
		host.start();
		host.xfer({dev, 1'b1}, 1'b1, q, a[1]);
		host.xfer(8'hff, 1'b1, q, a[0]);
		host.stop();
		chk({4'h0, a}, 8'h0e, "read acks");
		chk(q, exp, nm);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#500000;
		error_cnt++;
		$display("unexpected run length: expected done seen timeout");
		print_verdict();
	end
	initial begin
		logic [7:0] q;
		logic a;
		for (int i = 0; i < 8; i++) begin
			firstLvl = 3'(i) & 3'h5;
			secondLvl = 3'(i);
			addrLvl = 3'(i);
			reset_dut();
			chk({4'h0, dualPixelInput, repeaterEnable, bitMappingSelect, cableModeBit},
				{4'h0, firstLvl[2], firstLvl[0], secondLvl[2], secondLvl[1]}, "straps");
			chk({1'b0, slaveAddress}, 8'h0c + 8'(2 * i), "address");
		end
		dev = 7'h1a;
		rd(`LMS_REG_INPUT_CFG, 8'h80, "input cfg");
		rd(`LMS_REG_LINK_CTL, 8'h80, "link ctl");
		rd(`LMS_REG_RPT_CFG, 8'h20, "repeater cfg");
		rd(8'h40, 8'h00, "unmapped");
		wr(`LMS_REG_INPUT_CFG, 8'h40);
		chk({6'h0, dualPixelInput, bitMappingSelect}, 8'h00, "override");
		rd(`LMS_REG_INPUT_CFG, 8'h40, "readback");
		host.start();
		host.xfer({7'h0c, 1'b0}, 1'b1, q, a);
		host.stop();
		chk({7'h0, a}, 8'h00, "foreign ack");
		for (int k = 0; k < 4; k++) begin
			rx = autoTab[k][5:2];
			repeat (300) @(posedge core_clk);
			#1 chk({6'h0, linkMode}, {6'h0, autoTab[k][1:0]}, "auto mode");
		end
		rx = 4'h9;
		for (int c = 0; c < 4; c++) begin
			wr(`LMS_REG_LINK_CTL, {1'b1, 3'h0, 1'b1, 2'(c), 1'b1});
			chk({6'h0, linkMode}, 8'(c), "forced mode");
			chk({5'h0, secondaryTxEnable, singleProtectionSession, secondProtectionEngine},
				{5'h0, c != 0, c == 1, c == 2}, "enables");
		end
		// Forced single with an older receiver: slow pixel clock stays within limits
		wr(`LMS_REG_LINK_CTL, 8'h01);
		rx = 4'ha;
		repeat (300) @(posedge core_clk);
		#1 chk({6'h0, overRate, secondaryTxEnable}, 8'h00, "single rate");
		rd(`LMS_REG_STATUS, 8'h00, "status");
		print_verdict();
	end
endmodule // testbench
